// file: rtl/pvo_pkg.sv
package pvo_pkg;
  // register map and option field layout
  localparam logic [15:0] REG_OPT_ADDR = 16'h8205;
  localparam logic [15:0] REG_BOOT_ADDR = 16'h8500;
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam logic [7:0] BOOT_BUSY = 8'h01;
  localparam logic [7:0] BOOT_DONE = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam int OPT_LV_LOW_BIT = 0;
  localparam int OPT_FV_LOW_BIT = 1;
  localparam int OPT_WIDTH_LSB = 2;
  localparam int OPT_PKT_BIT = 4;
  localparam int OPT_CLK_INV_BIT = 6;
  localparam logic [1:0] WIDTH_12 = 2'h0;
  localparam logic [1:0] WIDTH_10 = 2'h1;
  localparam logic [1:0] WIDTH_8 = 2'h2;
  localparam logic [11:0] MASK_12 = 12'hFFF;
  localparam logic [11:0] MASK_10 = 12'hFFC;
  localparam logic [11:0] MASK_8 = 12'hFF0;
  // boot prom addressing
  localparam logic [7:0] PROM_ADDR_WR = 8'hA0;
  localparam logic [7:0] PROM_ADDR_RD = 8'hA1;
  // default frame geometry
  localparam int ACTIVE_PIX_DEF = 1024;
  localparam int HBLANK_DEF = 298;
  localparam int ACTIVE_LINES_DEF = 512;
  localparam int VBLANK_LINES_DEF = 168;
  localparam int PIX_CLK_DEF_HZ = 27_000_000;
  localparam int PIX_CLK_MAX_HZ = 54_000_000;
  // boot serial timing: quarter bit of a 100 kHz bus
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int TWM_QTR_NS = 2500;
  localparam int TWM_QTR_CYC = (TWM_QTR_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    BT_HOLD, BT_START, BT_WADDR, BT_RSTART, BT_RADDR, BT_READ, BT_STOP, BT_ENABLE, BT_DONE
  } pvo_boot_t;
endpackage

// file: rtl/pvo_video_out.sv
module pvo_video_out
  import pvo_pkg::*;
#(
  parameter int ACTIVE_PIX = ACTIVE_PIX_DEF,
  parameter int HBLANK = HBLANK_DEF,
  parameter int ACTIVE_LINES = ACTIVE_LINES_DEF,
  parameter int VBLANK_LINES = VBLANK_LINES_DEF,
  parameter int PIX_CLK_HZ = PIX_CLK_DEF_HZ,
  parameter int QTR_CYC = TWM_QTR_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic chip_reset_n_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic boot_scl_in,
  output logic boot_scl_out,
  output logic boot_scl_oe_out,
  input wire logic boot_sda_in,
  output logic boot_sda_out,
  output logic boot_sda_oe_out,
  output logic capture_enable_out,
  input wire logic pix_clk_in,
  input wire logic [11:0] pix_sample_in,
  output logic [11:0] pixel_bus_out,
  output logic line_valid_out,
  output logic frame_valid_out,
  output logic forwarded_pixel_clock_out
);
  localparam int TW = $clog2(QTR_CYC + 1);
  localparam logic [TW-1:0] QTR_LAST = TW'(QTR_CYC - 1);
  localparam logic [15:0] AP = 16'(ACTIVE_PIX);
  localparam logic [15:0] LINE_LAST = 16'(ACTIVE_PIX + HBLANK - 1);
  localparam logic [15:0] AL = 16'(ACTIVE_LINES);
  localparam logic [15:0] FRAME_LAST = 16'(ACTIVE_LINES + VBLANK_LINES - 1);
  localparam int CW = 7;

  // refuse a link clock above the limit
  if (PIX_CLK_HZ > PIX_CLK_MAX_HZ || ACTIVE_PIX < 1 || HBLANK < 1 || ACTIVE_LINES < 1 || VBLANK_LINES < 1 ||
      ACTIVE_PIX + HBLANK > 65535 || ACTIVE_LINES + VBLANK_LINES > 65535 || QTR_CYC < 2) begin : g_chk
    $error("pvo_video_out: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: {scl, sda, reset pin}; a bit moves when stages 2 and 3 agree
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, pin_f_d;
  always_comb begin
    pin_f_d = (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
  end
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_s1_q <= 3'h6;
      pin_s2_q <= 3'h6;
      pin_s3_q <= 3'h6;
      pin_f_q <= 3'h6;
    end else begin
      pin_s1_q <= {boot_scl_in, boot_sda_in, chip_reset_n_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= pin_f_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot sequencer with serial prom master, and the register file
  pvo_boot_t bt_q, bt_d;
  logic [TW-1:0] tick_q, tick_d;
  logic [1:0] qtr_q, qtr_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shf_q, shf_d, opt_q, opt_d, rdata_q, rdata_d;
  logic ack_q, ack_d, vid_en_q, vid_en_d, cap_en_q, cap_en_d;
  logic scl_lo_q, scl_lo_d, sda_lo_q, sda_lo_d;
  logic step, adv, writing;
  always_comb begin
    bt_d = bt_q;
    qtr_d = qtr_q;
    bit_d = bit_q;
    shf_d = shf_q;
    opt_d = opt_q;
    ack_d = ack_q;
    vid_en_d = vid_en_q;
    cap_en_d = cap_en_q;
    scl_lo_d = scl_lo_q;
    sda_lo_d = sda_lo_q;
    step = (tick_q == QTR_LAST);
    tick_d = step ? '0 : tick_q + TW'(1);
    // a slow prom may stretch the clock: once scl is released, wait for it to read high
    adv = step && !(qtr_q == 2'h2 && !pin_f_q[2]);
    writing = (bt_q == BT_WADDR) || (bt_q == BT_RADDR);
    if (adv) begin
      qtr_d = qtr_q + 2'h1;
    end
    case (bt_q)
      BT_HOLD: begin
        scl_lo_d = 1'b0;
        sda_lo_d = 1'b0;
        if (adv && qtr_q == 2'h3) begin
          bt_d = BT_START;
          shf_d = PROM_ADDR_WR;
        end
      end
      // start and repeated start on the boot wires
      BT_START, BT_RSTART: begin
        if (adv) begin
          case (qtr_q)
            2'h0: sda_lo_d = 1'b0;
            2'h1: scl_lo_d = 1'b0;
            2'h2: sda_lo_d = 1'b1;
            default: begin
              scl_lo_d = 1'b1;
              bit_d = 4'h0;
              bt_d = (bt_q == BT_START) ? BT_WADDR : BT_RADDR;
            end
          endcase
        end
      end
      // address probe, then single byte read
      BT_WADDR, BT_RADDR, BT_READ: begin
        if (adv) begin
          case (qtr_q)
            2'h0: sda_lo_d = writing && bit_q < 4'h8 && !shf_q[7];
            2'h1: scl_lo_d = 1'b0;
            2'h2: begin
              if (bit_q < 4'h8) begin
                shf_d = {shf_q[6:0], pin_f_q[1]};
              end else if (writing) begin
                ack_d = !pin_f_q[1];
              end
            end
            default: begin
              scl_lo_d = 1'b1;
              bit_d = bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                if (bt_q == BT_READ) begin
                  opt_d = shf_q;
                  bt_d = BT_STOP;
                end else if (!ack_q) begin
                  bt_d = BT_STOP;
                end else if (bt_q == BT_WADDR) begin
                  shf_d = PROM_ADDR_RD;
                  bt_d = BT_RSTART;
                end else begin
                  bt_d = BT_READ;
                end
              end
            end
          endcase
        end
      end
      BT_STOP: begin
        if (adv) begin
          case (qtr_q)
            2'h0: sda_lo_d = 1'b1;
            2'h1: scl_lo_d = 1'b0;
            2'h2: sda_lo_d = 1'b0;
            default: bt_d = BT_ENABLE;
          endcase
        end
      end
      // capture and video on once the prom step is over
      BT_ENABLE: begin
        cap_en_d = 1'b1;
        vid_en_d = 1'b1;
        bt_d = BT_DONE;
      end
      BT_DONE: begin
      end
      default: bt_d = BT_HOLD;
    endcase
    if (reg_wr_in && reg_addr_in == REG_OPT_ADDR) begin
      opt_d = reg_wdata_in;
    end
    // flag reads busy until the sequencer is done
    if (reg_addr_in == REG_OPT_ADDR) begin
      rdata_d = opt_q;
    end else if (reg_addr_in == REG_BOOT_ADDR) begin
      rdata_d = (bt_q == BT_DONE) ? BOOT_DONE : BOOT_BUSY;
    end else begin
      rdata_d = RD_UNMAPPED;
    end
    // reset pin low holds the sequencer, options, enables and boot wires at defaults
    if (!pin_f_q[0]) begin
      bt_d = BT_HOLD;
      opt_d = OPT_RESET;
      vid_en_d = 1'b0;
      cap_en_d = 1'b0;
      scl_lo_d = 1'b0;
      sda_lo_d = 1'b0;
      ack_d = 1'b0;
    end
  end
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bt_q <= BT_HOLD;
      tick_q <= '0;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      shf_q <= 8'h00;
      opt_q <= OPT_RESET;
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
      vid_en_q <= 1'b0;
      cap_en_q <= 1'b0;
      scl_lo_q <= 1'b0;
      sda_lo_q <= 1'b0;
    end else begin
      bt_q <= bt_d;
      tick_q <= tick_d;
      qtr_q <= qtr_d;
      bit_q <= bit_d;
      shf_q <= shf_d;
      opt_q <= opt_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      vid_en_q <= vid_en_d;
      cap_en_q <= cap_en_d;
      scl_lo_q <= scl_lo_d;
      sda_lo_q <= sda_lo_d;
    end
  end
  assign reg_rdata_out = rdata_q;
  assign boot_scl_out = 1'b0;
  assign boot_scl_oe_out = scl_lo_q;
  assign boot_sda_out = 1'b0;
  assign boot_sda_oe_out = sda_lo_q;
  assign capture_enable_out = cap_en_q;

  property p_enable_done;
    @(posedge sys_clk_in) disable iff (reset_in) $rose(vid_en_q) |-> bt_q == BT_DONE && cap_en_q;
  endproperty
  a_enable_done: assert property (p_enable_done) else $error("video enabled outside boot completion");
  property p_flag_busy;
    @(posedge sys_clk_in) disable iff (reset_in)
      reg_addr_in == REG_BOOT_ADDR && bt_q != BT_DONE |=> reg_rdata_out == BOOT_BUSY;
  endproperty
  a_flag_busy: assert property (p_flag_busy) else $error("boot flag read zero before done");
  property p_pin_hold;
    @(posedge sys_clk_in) disable iff (reset_in) !pin_f_q[0] |=> bt_q == BT_HOLD && !vid_en_q && opt_q == OPT_RESET;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("boot advanced with reset pin low");

  ////////////////////////////////////////////////////////////////////////////
  // link clock domain: reset release and quasi-static settings crossing
  logic [1:0] prst_q;
  logic prst;
  always_ff @(posedge pix_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prst_q <= 2'h3;
    end else begin
      prst_q <= {prst_q[0], 1'b0};
    end
  end
  assign prst = prst_q[1];

  // the word moves only when stages 2 and 3 agree as a whole, so a half-changed word never lands
  logic [CW-1:0] cs1_q, cs2_q, cs3_q, cf_q, cf_d;
  always_comb begin
    cf_d = (cs2_q == cs3_q) ? cs3_q : cf_q;
  end
  always_ff @(posedge pix_clk_in or posedge prst) begin
    if (prst) begin
      cs1_q <= '0;
      cs2_q <= '0;
      cs3_q <= '0;
      cf_q <= '0;
    end else begin
      cs1_q <= {vid_en_q, opt_q[OPT_CLK_INV_BIT], opt_q[OPT_PKT_BIT:0]};
      cs2_q <= cs1_q;
      cs3_q <= cs2_q;
      cf_q <= cf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame timing and output registers
  logic [15:0] col_q, col_d, row_q, row_d, hi_q, hi_d, lo_q, lo_d;
  logic [11:0] data_q, data_d, mask;
  logic [5:0] cfg_q, cfg_d;
  logic run_q, run_d, lv_q, lv_d, fv_q, fv_d, lvo_q, lvo_d, fvo_q, fvo_d;
  always_comb begin
    run_d = cf_q[6];
    col_d = col_q;
    row_d = row_q;
    cfg_d = cfg_q;
    // column counter steps once per link clock, row counter once per line
    if (!run_q) begin
      col_d = 16'h0000;
      row_d = 16'h0000;
    end else if (col_q == LINE_LAST) begin
      col_d = 16'h0000;
      row_d = (row_q == FRAME_LAST) ? 16'h0000 : row_q + 16'h0001;
    end else begin
      col_d = col_q + 16'h0001;
    end
    if (!run_q || (row_q == AL && col_q == 16'h0000)) begin
      cfg_d = cf_q[5:0];
    end
    // rows from top, columns from left
    // strobe only over the active pixels
    lv_d = run_q && row_q < AL && col_q < AP;
    // frame strobe spans first to last line strobe
    // remaining rows form the vertical blank
    fv_d = run_q && row_q < AL && !(row_q == AL - 16'h0001 && col_q >= AP);
    // unused low bits forced to zero
    case (cfg_q[OPT_WIDTH_LSB+1:OPT_WIDTH_LSB])
      WIDTH_10: mask = MASK_10;
      WIDTH_8: mask = MASK_8;
      default: mask = MASK_12;
    endcase
    // bus stays zero outside active pixels
    data_d = lv_d ? (pix_sample_in & mask) : 12'h000;
    // packetized mode parks both strobes low
    lvo_d = !cfg_q[OPT_PKT_BIT] && (lv_d ^ cfg_q[OPT_LV_LOW_BIT]);
    fvo_d = !cfg_q[OPT_PKT_BIT] && (fv_d ^ cfg_q[OPT_FV_LOW_BIT]);
    hi_d = lv_q ? hi_q + 16'h0001 : 16'h0000;
    lo_d = lv_q ? 16'h0000 : lo_q + 16'h0001;
  end
  always_ff @(posedge pix_clk_in or posedge prst) begin
    if (prst) begin
      run_q <= 1'b0;
      col_q <= 16'h0000;
      row_q <= 16'h0000;
      cfg_q <= 6'h00;
      lv_q <= 1'b0;
      fv_q <= 1'b0;
      lvo_q <= 1'b0;
      fvo_q <= 1'b0;
      data_q <= 12'h000;
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
    end else begin
      run_q <= run_d;
      col_q <= col_d;
      row_q <= row_d;
      cfg_q <= cfg_d;
      lv_q <= lv_d;
      fv_q <= fv_d;
      lvo_q <= lvo_d;
      fvo_q <= fvo_d;
      data_q <= data_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end
  assign pixel_bus_out = data_q;
  assign line_valid_out = lvo_q;
  assign frame_valid_out = fvo_q;
  // inversion moves the launch to the falling edge
  // default launches on the rising edge
  // receiver must sample on this clock; setting only changes in blanking
  assign forwarded_pixel_clock_out = pix_clk_in ^ cfg_q[5];

  property p_low_bits_zero;
    @(posedge pix_clk_in) disable iff (prst)
      $past(cfg_q[OPT_WIDTH_LSB+1:OPT_WIDTH_LSB]) == WIDTH_8 |-> pixel_bus_out[3:0] == 4'h0;
  endproperty
  a_low_bits_zero: assert property (p_low_bits_zero) else $error("low bus bits nonzero in 8-bit mode");
  property p_idle_quiet;
    @(posedge pix_clk_in) disable iff (prst) !run_q |=> pixel_bus_out == 12'h000 && !fv_q && !lv_q;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output active before enable");
  property p_fv_rise;
    @(posedge pix_clk_in) disable iff (prst) $rose(fv_q) |-> $rose(lv_q);
  endproperty
  a_fv_rise: assert property (p_fv_rise) else $error("frame strobe rose without line strobe");
  property p_fv_fall;
    @(posedge pix_clk_in) disable iff (prst) $fell(fv_q) |-> $fell(lv_q);
  endproperty
  a_fv_fall: assert property (p_fv_fall) else $error("frame strobe fell apart from line strobe");
  property p_hblank;
    @(posedge pix_clk_in) disable iff (prst) $rose(lv_q) && $past(fv_q) |-> lo_q == 16'(HBLANK);
  endproperty
  a_hblank: assert property (p_hblank) else $error("horizontal blank length wrong");
  property p_line_len;
    @(posedge pix_clk_in) disable iff (prst) $fell(lv_q) |-> hi_q == AP;
  endproperty
  a_line_len: assert property (p_line_len) else $error("active line length wrong");
  property p_polarity;
    @(posedge pix_clk_in) disable iff (prst)
      fv_q && !cfg_q[OPT_PKT_BIT] |-> line_valid_out == (lv_q ^ cfg_q[OPT_LV_LOW_BIT]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("line strobe polarity wrong");
  property p_pkt_low;
    @(posedge pix_clk_in) disable iff (prst)
      $past(cfg_q[OPT_PKT_BIT]) && cfg_q[OPT_PKT_BIT] |-> !line_valid_out && !frame_valid_out;
  endproperty
  a_pkt_low: assert property (p_pkt_low) else $error("strobe driven in packetized mode");
endmodule

// file: tb/pvo_capture_model.sv
module pvo_capture_model (
  input wire logic clk_in,
  input wire logic lv_low_in,
  input wire logic fv_low_in,
  input wire logic line_valid_in,
  input wire logic frame_valid_in,
  input wire logic [11:0] pixel_bus_in,
  output logic ev_out,
  output logic ev_first_out,
  output logic ev_fv_bad_out,
  output logic [15:0] ev_len_out,
  output logic [15:0] ev_gap_out,
  output logic [15:0] ev_fgap_out,
  output logic [11:0] ev_word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lv, fv, lv_q, fv_q, bad_q;
  logic [15:0] len_q, gap_q, fgap_q;
  logic [11:0] word_q;
  assign lv = line_valid_in ^ lv_low_in;
  assign fv = frame_valid_in ^ fv_low_in;
  ////////////////////////////////////////////////////////////
  // capture on forwarded clock
  always @(posedge clk_in) begin
    ev_out <= lv_q && !lv;
    if (lv && !lv_q) begin
      ev_gap_out <= gap_q;
      ev_fgap_out <= fgap_q;
      ev_first_out <= fv && !fv_q;
    end
    if (lv_q && !lv) begin
      ev_len_out <= len_q;
      ev_word_out <= word_q;
      ev_fv_bad_out <= bad_q;
    end
    // a line seen outside the frame strobe is flagged, not dropped
    bad_q <= (lv && !lv_q) ? !fv : (bad_q || (lv && !fv));
    len_q <= lv ? len_q + 16'h0001 : 16'h0000;
    gap_q <= lv ? 16'h0000 : gap_q + 16'h0001;
    fgap_q <= fv ? 16'h0000 : fgap_q + 16'h0001;
    if (lv) begin
      word_q <= pixel_bus_in;
    end
    lv_q <= lv;
    fv_q <= fv;
  end
endmodule

// file: tb/pvo_video_out_tb.sv
module pvo_video_out_tb
  import pvo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AP = 8;
  localparam int HB = 5;
  localparam int AL = 3;
  localparam int VB = 2;
  typedef struct {
    logic [15:0] len;
    logic [15:0] gap;
    logic [15:0] fgap;
    logic first;
    logic [11:0] word;
  } pvo_note_t;
  logic sys_clk, pix_clk, reset, rst_n, wr, lv_low, fv_low;
  logic scl_oe, sda_oe, scl_w, sda_w, cap_en, lv, fv, fwd, ev, ev_first, ev_bad;
  logic [15:0] addr, ev_len, ev_gap, ev_fgap;
  logic [7:0] wdata, rdata, probe;
  logic [11:0] sample, bus, ev_word;
  logic [7:0] cfg [4];
  pvo_note_t q[$];
  pvo_note_t nw;
  int failures, checked, seed, nbit;
  // open-drain boot wires with pull-ups and no prom fitted
  assign scl_w = !scl_oe;
  assign sda_w = !sda_oe;

  pvo_video_out #(.ACTIVE_PIX(AP), .HBLANK(HB), .ACTIVE_LINES(AL), .VBLANK_LINES(VB), .QTR_CYC(3)) i_dut (
    .sys_clk_in(sys_clk), .reset_in(reset), .chip_reset_n_in(rst_n), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .boot_scl_in(scl_w), .boot_scl_out(), .boot_scl_oe_out(scl_oe),
    .boot_sda_in(sda_w), .boot_sda_out(), .boot_sda_oe_out(sda_oe),
    .capture_enable_out(cap_en), .pix_clk_in(pix_clk), .pix_sample_in(sample),
    .pixel_bus_out(bus), .line_valid_out(lv), .frame_valid_out(fv), .forwarded_pixel_clock_out(fwd)
  );

  pvo_capture_model i_rx (
    .clk_in(fwd), .lv_low_in(lv_low), .fv_low_in(fv_low), .line_valid_in(lv), .frame_valid_in(fv),
    .pixel_bus_in(bus), .ev_out(ev), .ev_first_out(ev_first), .ev_fv_bad_out(ev_bad),
    .ev_len_out(ev_len), .ev_gap_out(ev_gap), .ev_fgap_out(ev_fgap), .ev_word_out(ev_word)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    pix_clk = 1'b0;
    #7;
    forever #15 pix_clk = ~pix_clk;
  end
  ////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task timeout(input string what);
    failures++;
    $display("mismatch %s expected done seen timeout", what);
    results();
  endtask
  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge sys_clk);
    wr = 1'b0;
  endtask
  task rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    addr = a;
    repeat (2) @(negedge sys_clk);
    d = rdata;
  endtask
  task wait_first;
    int n;
    n = 0;
    do begin
      @(posedge fwd);
      n++;
      if (n > 3000) timeout("frame start");
    end while (!(ev && ev_first));
  endtask
  // settings latch at a frame boundary, so skip frames before noting
  task run_frame(input logic [11:0] word);
    pvo_note_t nt;
    int n;
    repeat (3) wait_first();
    @(negedge fwd);
    for (int i = 1; i <= AL; i++) begin
      nt.len = 16'(AP);
      nt.gap = (i < AL) ? 16'(HB) : 16'(VB * (AP + HB) + HB);
      nt.fgap = (i < AL) ? 16'h0000 : nt.gap;
      nt.first = (i == AL);
      nt.word = word;
      q.push_back(nt);
    end
    n = 0;
    while (q.size() > 0) begin
      @(posedge fwd);
      n++;
      if (n > 3000) timeout("line results");
    end
  endtask
  ////////////////////////////////////////////////////////////
  always @(negedge sda_w) if (scl_w) nbit = 0;
  always @(posedge scl_w) begin
    if (nbit < 8) probe = {probe[6:0], sda_w};
    nbit++;
  end
  always @(posedge fwd) begin
    if (ev && q.size() > 0) begin
      nw = q.pop_front();
      check("line length", nw.len, ev_len);
      check("line gap", nw.gap, ev_gap);
      check("frame gap", nw.fgap, ev_fgap);
      check("frame start", nw.first, ev_first);
      check("frame strobe", 0, ev_bad);
      check("pixel word", nw.word, ev_word);
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [11:0] m;
    int k;
    seed = 32'h7c84;
    cfg = '{8'h00, 8'h07, 8'h48, 8'h4D};
    {reset, rst_n, wr, lv_low, fv_low} = 5'h10;
    addr = 16'h0000;
    wdata = 8'h00;
    sample = 12'h000;
    failures = 0;
    checked = 0;
    nbit = 0;
    probe = 8'h00;
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    repeat (20) @(negedge sys_clk);
    rd_reg(REG_BOOT_ADDR, d);
    check("boot flag", BOOT_BUSY, d);
    check("capture early", 0, cap_en);
    check("idle outputs", 0, {lv, fv, bus});
    rd_reg(REG_OPT_ADDR, d);
    check("option reset", OPT_RESET, d);
    rst_n = 1'b1;
    k = 0;
    do begin
      rd_reg(REG_BOOT_ADDR, d);
      k++;
      if (k > 1000) timeout("boot");
    end while (d !== BOOT_DONE);
    check("capture", 1, cap_en);
    check("probe address", PROM_ADDR_WR, probe);
    $display("test boot finished");
    wr_reg(REG_BOOT_ADDR, 8'h5A);
    rd_reg(REG_BOOT_ADDR, d);
    check("boot flag read only", BOOT_DONE, d);
    rd_reg(16'h1234, d);
    check("unmapped", RD_UNMAPPED, d);
    $display("test registers finished");
    for (int t = 0; t < 4; t++) begin
      @(negedge pix_clk);
      sample = 12'($random(seed));
      wr_reg(REG_OPT_ADDR, cfg[t]);
      rd_reg(REG_OPT_ADDR, d);
      check("option", cfg[t], d);
      lv_low = cfg[t][OPT_LV_LOW_BIT];
      fv_low = cfg[t][OPT_FV_LOW_BIT];
      m = (cfg[t][3:2] == WIDTH_10) ? MASK_10 : (cfg[t][3:2] == WIDTH_8) ? MASK_8 : MASK_12;
      run_frame(sample & m);
      // the clock setting only lands at vertical blank, so look once frames have run
      @(negedge sys_clk);
      check("pixel clock", pix_clk ^ cfg[t][OPT_CLK_INV_BIT], fwd);
      $display("test video option %h finished", cfg[t]);
    end
    wr_reg(REG_OPT_ADDR, 8'h13);
    repeat (300) @(negedge sys_clk);
    k = 0;
    repeat (200) begin
      @(negedge sys_clk);
      if (lv !== 1'b0 || fv !== 1'b0) k++;
    end
    check("packet strobes", 0, k);
    $display("test packetized finished");
    results();
  end
endmodule
